// File: logic/tpc_pkg.sv
// Constants and types shared by the Type B parameter checker
package tpc_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_ID_LO     = 12'h004;
   localparam logic [11:0] ADDR_ID_HI     = 12'h008;
   localparam logic [11:0] ADDR_MEM_LAST  = 12'h00c;
   localparam logic [11:0] ADDR_SEL_PARAM = 12'h010;
   localparam logic [11:0] ADDR_STATUS    = 12'h014;
   localparam logic [11:0] ADDR_PUPI      = 12'h018;
   localparam logic [11:0] ADDR_FWT       = 12'h01c;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          CTRL_AFI_LSB  = 0;
   localparam int          CTRL_FWI_LSB  = 8;
   localparam int          SEL_P1_LSB    = 8;
   localparam int          P1_TOP_BIT    = 7;
   localparam logic [7:0]  AFI_RST       = 8'h00;
   localparam logic [3:0]  FWI_RST       = 4'h0;
   localparam logic [3:0]  FWI_MAX       = 4'he;
   localparam logic [31:0] ID_RST        = 32'h00000000;
   localparam logic [11:0] MEM_LAST_RST  = 12'hfff;
   localparam logic [7:0]  SEL_P1_RST    = 8'h04;
   localparam logic [7:0]  SEL_P2_RST    = 8'h00;

   // ------------------------------------------------------------
   // Status words and mode codes
   // ------------------------------------------------------------
   localparam logic [7:0]  SW1_OK        = 8'h90;
   localparam logic [7:0]  SW2_OK        = 8'h00;
   localparam logic [7:0]  SW1_PARAM     = 8'h6a;
   localparam logic [7:0]  SW2_PARAM     = 8'h86;
   localparam logic [7:0]  SW1_LEN       = 8'h67;
   localparam logic [7:0]  SW2_LEN       = 8'h00;
   localparam logic [2:0]  P1_MODE_PLAIN = 3'h0;
   localparam logic [2:0]  P1_MODE_PRIV  = 3'h2;
   localparam logic [2:0]  P1_MODE_FAM   = 3'h3;
   localparam logic [7:0]  BLK_BYTES     = 8'h10;
   localparam logic [7:0]  ENC_OVERHEAD  = 8'h20;

   // ------------------------------------------------------------
   // Timing: base wait is 256 x 16 carrier periods
   // ------------------------------------------------------------
   localparam int          FC_KHZ        = 13560;
   localparam int          CLK_KHZ       = 125000;
   localparam int          FWT_BASE_FC   = 256 * 16;
   localparam logic [31:0] FWT_BASE_CYC  = 32'(FWT_BASE_FC * CLK_KHZ / FC_KHZ);

   typedef enum logic [1:0] {
      TPC_CMD_REQB   = 2'b00,
      TPC_CMD_READ   = 2'b01,
      TPC_CMD_WRITE  = 2'b10,
      TPC_CMD_SELECT = 2'b11
   } tpc_cmd_t;

   typedef enum logic [1:0] {
      TPC_MODE_PLAIN = 2'b00,
      TPC_MODE_PRIV  = 2'b01,
      TPC_MODE_FAM   = 2'b10
   } tpc_mode_t;

   typedef enum logic [1:0] {
      TPC_FWT_IDLE    = 2'b00,
      TPC_FWT_RUN     = 2'b01,
      TPC_FWT_EXPIRED = 2'b10
   } tpc_fwt_state_t;

endpackage

// File: logic/tpc_fwt_timer.sv
// Frame waiting time counter
`timescale 1ns/1ps
module tpc_fwt_timer (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic        i_stop,
   input  wire logic [31:0] i_limit,
   output logic             o_timeout,
   output logic             o_running
);

   tpc_pkg::tpc_fwt_state_t state_reg;
   logic [31:0]             cnt_reg;
   logic [31:0]             lim_reg;

   // ------------------------------------------------------------
   // Wait state machine
   // ------------------------------------------------------------
   // Limit is latched at start so a software FWI change cannot
   // stretch or cut a wait already in progress.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= tpc_pkg::TPC_FWT_IDLE;
         cnt_reg   <= 32'h00000000;
         lim_reg   <= 32'h00000000;
      end else if (i_start) begin
         state_reg <= tpc_pkg::TPC_FWT_RUN;
         cnt_reg   <= 32'h00000000;
         lim_reg   <= i_limit;
      end else begin
         unique case (state_reg)
            tpc_pkg::TPC_FWT_IDLE: begin
               state_reg <= tpc_pkg::TPC_FWT_IDLE;
            end
            tpc_pkg::TPC_FWT_RUN: begin
               if (i_stop) begin
                  state_reg <= tpc_pkg::TPC_FWT_IDLE;
               end else if (cnt_reg == lim_reg - 32'h00000001) begin
                  state_reg <= tpc_pkg::TPC_FWT_EXPIRED;
               end else begin
                  cnt_reg <= cnt_reg + 32'h00000001;
               end
            end
            tpc_pkg::TPC_FWT_EXPIRED: begin
               if (i_stop) begin
                  state_reg <= tpc_pkg::TPC_FWT_IDLE;
               end
            end
            default: begin
               state_reg <= tpc_pkg::TPC_FWT_IDLE;
            end
         endcase
      end
   end

   assign o_timeout = (state_reg == tpc_pkg::TPC_FWT_EXPIRED);
   assign o_running = (state_reg == tpc_pkg::TPC_FWT_RUN);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_fwt_expire;
      @(posedge i_clk) disable iff (i_rst)
      o_running && !i_start && !i_stop && cnt_reg == lim_reg - 32'h00000001
      |=> o_timeout;
   endproperty
   a_fwt_expire: assert property (p_fwt_expire) else $error("wait did not expire at limit");

   property p_fwt_exact;
      @(posedge i_clk) disable iff (i_rst)
      $rose(o_timeout) |-> $past(cnt_reg) == $past(lim_reg) - 32'h00000001;
   endproperty
   a_fwt_exact: assert property (p_fwt_exact) else $error("wait expired early");

   c_fwt_timeout: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_timeout));

endmodule

// File: logic/tpc_top.sv
// Type B parameter checker: family filter, identifier, wait time, address and mode decode
`timescale 1ns/1ps
module tpc_top #(
   parameter logic [31:0] FWT_BASE_CYC = tpc_pkg::FWT_BASE_CYC
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_CMD_VALID,
   input  wire logic [1:0]  I_CMD_KIND,
   input  wire logic [7:0]  I_CMD_AFI,
   input  wire logic [7:0]  I_CMD_P1,
   input  wire logic [7:0]  I_CMD_P2,
   input  wire logic [7:0]  I_CMD_LEN,
   output logic             O_RSP_VALID,
   output logic             O_RSP_ANSWER,
   output logic [7:0]       O_RSP_SW1,
   output logic [7:0]       O_RSP_SW2,
   output logic [1:0]       O_RSP_MODE,
   output logic [11:0]      O_RSP_ADDR,
   output logic [7:0]       O_PAY_OFF,
   output logic [7:0]       O_PAY_LEN,
   output logic [31:0]      O_PUPI,
   output logic [3:0]       O_FWI,
   input  wire logic        I_FWT_START,
   input  wire logic        I_FWT_STOP,
   output logic             O_FWT_TIMEOUT,
   output logic             O_FWT_RUNNING
);

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0]  afi_reg;
   logic [3:0]  fwi_reg;
   logic [31:0] id_lo_reg;
   logic [31:0] id_hi_reg;
   logic [11:0] mem_last_reg;
   logic [7:0]  sel_p1_reg;
   logic [7:0]  sel_p2_reg;
   logic [7:0]  rej_cnt_reg;
   logic [31:0] fwt_limit;
   logic        wr_en;
   logic        setup;
   logic [3:0]  fwi_wr;
   logic [31:0] rdata_next;
   logic        slverr_next;

   assign wr_en    = I_PSEL && I_PENABLE && I_PWRITE;
   assign setup    = I_PSEL && !I_PENABLE;
   assign O_PREADY = 1'b1;
   assign fwi_wr   = I_PWDATA[tpc_pkg::CTRL_FWI_LSB +: 4];

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         afi_reg      <= tpc_pkg::AFI_RST;
         fwi_reg      <= tpc_pkg::FWI_RST;
         id_lo_reg    <= tpc_pkg::ID_RST;
         id_hi_reg    <= tpc_pkg::ID_RST;
         mem_last_reg <= tpc_pkg::MEM_LAST_RST;
         sel_p1_reg   <= tpc_pkg::SEL_P1_RST;
         sel_p2_reg   <= tpc_pkg::SEL_P2_RST;
      end else if (wr_en) begin
         unique case (I_PADDR)
            tpc_pkg::ADDR_CTRL: begin
               afi_reg <= I_PWDATA[tpc_pkg::CTRL_AFI_LSB +: 8];
               // Out-of-range integers saturate rather than wrap
               fwi_reg <= (fwi_wr > tpc_pkg::FWI_MAX) ? tpc_pkg::FWI_MAX : fwi_wr;
            end
            tpc_pkg::ADDR_ID_LO: begin
               id_lo_reg <= I_PWDATA;
            end
            tpc_pkg::ADDR_ID_HI: begin
               id_hi_reg <= I_PWDATA;
            end
            tpc_pkg::ADDR_MEM_LAST: begin
               mem_last_reg <= I_PWDATA[11:0];
            end
            tpc_pkg::ADDR_SEL_PARAM: begin
               sel_p1_reg <= I_PWDATA[tpc_pkg::SEL_P1_LSB +: 8];
               sel_p2_reg <= I_PWDATA[7:0];
            end
            default: begin
               afi_reg <= afi_reg;
            end
         endcase
      end
   end

   assign O_PUPI    = id_lo_reg;
   assign O_FWI     = fwi_reg;
   assign fwt_limit = FWT_BASE_CYC << fwi_reg;

   // Read data is captured in the setup phase, so no wait state is needed
   always_comb begin
      rdata_next  = 32'h00000000;
      slverr_next = 1'b0;
      unique case (I_PADDR)
         tpc_pkg::ADDR_CTRL:      rdata_next = {20'h00000, fwi_reg, afi_reg};
         tpc_pkg::ADDR_ID_LO:     rdata_next = id_lo_reg;
         tpc_pkg::ADDR_ID_HI:     rdata_next = id_hi_reg;
         tpc_pkg::ADDR_MEM_LAST:  rdata_next = {20'h00000, mem_last_reg};
         tpc_pkg::ADDR_SEL_PARAM: rdata_next = {16'h0000, sel_p1_reg, sel_p2_reg};
         tpc_pkg::ADDR_STATUS:    rdata_next = {rej_cnt_reg, 5'h00, O_RSP_ANSWER,
                                                O_RSP_MODE, O_RSP_SW1, O_RSP_SW2};
         tpc_pkg::ADDR_PUPI:      rdata_next = id_lo_reg;
         tpc_pkg::ADDR_FWT:       rdata_next = fwt_limit;
         default:                 slverr_next = 1'b1;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PRDATA  <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end else if (setup) begin
         O_PRDATA  <= I_PWRITE ? 32'h00000000 : rdata_next;
         O_PSLVERR <= slverr_next;
      end
   end

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   tpc_pkg::tpc_cmd_t  cmd_kind;
   tpc_pkg::tpc_mode_t mode_c;
   logic [2:0]  mode_bits;
   logic [11:0] addr_c;
   logic        afi_hit;
   logic        mode_ok;
   logic        enc;
   logic        p1_err;
   logic        len_err;
   logic        sel_hit;
   logic        rsp_c;
   logic        answer_c;
   logic [7:0]  sw1_c;
   logic [7:0]  sw2_c;
   logic [7:0]  pay_off_c;
   logic [7:0]  pay_len_c;

   assign cmd_kind  = tpc_pkg::tpc_cmd_t'(I_CMD_KIND);
   assign mode_bits = I_CMD_P1[6:4];
   assign addr_c    = {I_CMD_P1[3:0], I_CMD_P2};
   assign sel_hit   = (I_CMD_P1 == sel_p1_reg) && (I_CMD_P2 == sel_p2_reg);

   always_comb begin
      if (I_CMD_AFI == 8'h00) begin
         afi_hit = 1'b1;
      end else if (I_CMD_AFI[3:0] == 4'h0) begin
         afi_hit = (I_CMD_AFI[7:4] == afi_reg[7:4]);
      end else if (I_CMD_AFI[7:4] == 4'h0) begin
         afi_hit = (I_CMD_AFI[3:0] == afi_reg[3:0]);
      end else begin
         afi_hit = (I_CMD_AFI == afi_reg);
      end
   end

   always_comb begin
      mode_ok = 1'b1;
      mode_c  = tpc_pkg::TPC_MODE_PLAIN;
      if (mode_bits == tpc_pkg::P1_MODE_PRIV) begin
         mode_c = tpc_pkg::TPC_MODE_PRIV;
      end else if (mode_bits == tpc_pkg::P1_MODE_FAM) begin
         mode_c = tpc_pkg::TPC_MODE_FAM;
      end else if (mode_bits != tpc_pkg::P1_MODE_PLAIN) begin
         mode_ok = 1'b0;
      end
   end

   assign enc     = mode_ok && (mode_c != tpc_pkg::TPC_MODE_PLAIN);
   // Parameter byte checks rank above length checks
   assign p1_err  = I_CMD_P1[tpc_pkg::P1_TOP_BIT] || !mode_ok
                    || (addr_c > mem_last_reg)
                    || (enc && addr_c[3:0] != 4'h0);
   // A vector and a code alone already take 32 bytes
   assign len_err = enc && (I_CMD_LEN[3:0] != 4'h0 || I_CMD_LEN < tpc_pkg::ENC_OVERHEAD);

   always_comb begin
      rsp_c     = 1'b1;
      answer_c  = 1'b0;
      sw1_c     = tpc_pkg::SW1_OK;
      sw2_c     = tpc_pkg::SW2_OK;
      pay_off_c = 8'h00;
      pay_len_c = 8'h00;
      unique case (cmd_kind)
         tpc_pkg::TPC_CMD_REQB: begin
            rsp_c    = afi_hit;
            answer_c = afi_hit;
         end
         tpc_pkg::TPC_CMD_SELECT: begin
            if (!sel_hit) begin
               sw1_c = tpc_pkg::SW1_PARAM;
               sw2_c = tpc_pkg::SW2_PARAM;
            end
         end
         tpc_pkg::TPC_CMD_READ, tpc_pkg::TPC_CMD_WRITE: begin
            if (p1_err) begin
               sw1_c = tpc_pkg::SW1_PARAM;
               sw2_c = tpc_pkg::SW2_PARAM;
            end else if (len_err) begin
               sw1_c = tpc_pkg::SW1_LEN;
               sw2_c = tpc_pkg::SW2_LEN;
            end else if (enc) begin
               pay_off_c = tpc_pkg::BLK_BYTES;
               pay_len_c = I_CMD_LEN - tpc_pkg::ENC_OVERHEAD;
            end else begin
               pay_len_c = I_CMD_LEN;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Response registers
   // ------------------------------------------------------------
   // An unmatched request leaves the last response fields untouched
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RSP_VALID  <= 1'b0;
         O_RSP_ANSWER <= 1'b0;
         O_RSP_SW1    <= 8'h00;
         O_RSP_SW2    <= 8'h00;
         O_RSP_MODE   <= tpc_pkg::TPC_MODE_PLAIN;
         O_RSP_ADDR   <= 12'h000;
         O_PAY_OFF    <= 8'h00;
         O_PAY_LEN    <= 8'h00;
      end else begin
         O_RSP_VALID <= I_CMD_VALID && rsp_c;
         if (I_CMD_VALID && rsp_c) begin
            O_RSP_ANSWER <= answer_c;
            O_RSP_SW1    <= sw1_c;
            O_RSP_SW2    <= sw2_c;
            O_RSP_MODE   <= mode_c;
            O_RSP_ADDR   <= addr_c;
            O_PAY_OFF    <= pay_off_c;
            O_PAY_LEN    <= pay_len_c;
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rej_cnt_reg <= 8'h00;
      end else if (I_CMD_VALID && rsp_c && sw1_c != tpc_pkg::SW1_OK
                   && rej_cnt_reg != 8'hff) begin
         rej_cnt_reg <= rej_cnt_reg + 8'h01;
      end
   end

   tpc_fwt_timer u_fwt (
      .i_clk     (I_CLK),
      .i_rst     (I_RST),
      .i_start   (I_FWT_START),
      .i_stop    (I_FWT_STOP),
      .i_limit   (fwt_limit),
      .o_timeout (O_FWT_TIMEOUT),
      .o_running (O_FWT_RUNNING)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   logic reqb_v;
   logic rw_v;
   assign reqb_v = I_CMD_VALID && cmd_kind == tpc_pkg::TPC_CMD_REQB;
   assign rw_v   = I_CMD_VALID && (cmd_kind == tpc_pkg::TPC_CMD_READ
                                   || cmd_kind == tpc_pkg::TPC_CMD_WRITE);

   property p_afi_zero;
      reqb_v && I_CMD_AFI == 8'h00 |=> O_RSP_VALID && O_RSP_ANSWER;
   endproperty
   a_afi_zero: assert property (p_afi_zero) else $error("family zero not answered");

   property p_afi_hi;
      reqb_v && I_CMD_AFI[3:0] == 4'h0 && I_CMD_AFI[7:4] != 4'h0
      |=> O_RSP_VALID == ($past(I_CMD_AFI[7:4]) == $past(afi_reg[7:4]));
   endproperty
   a_afi_hi: assert property (p_afi_hi) else $error("upper nibble filter wrong");

   property p_afi_lo;
      reqb_v && I_CMD_AFI[7:4] == 4'h0 && I_CMD_AFI[3:0] != 4'h0
      |=> O_RSP_VALID == ($past(I_CMD_AFI[3:0]) == $past(afi_reg[3:0]));
   endproperty
   a_afi_lo: assert property (p_afi_lo) else $error("lower nibble filter wrong");

   property p_afi_full;
      reqb_v && I_CMD_AFI[7:4] != 4'h0 && I_CMD_AFI[3:0] != 4'h0
      |=> O_RSP_VALID == ($past(I_CMD_AFI) == $past(afi_reg));
   endproperty
   a_afi_full: assert property (p_afi_full) else $error("full family filter wrong");

   property p_pupi;
      wr_en && I_PADDR == tpc_pkg::ADDR_ID_LO |=> O_PUPI == $past(I_PWDATA);
   endproperty
   a_pupi: assert property (p_pupi) else $error("identifier not from low word");

   property p_fwi_max;
      fwi_reg <= tpc_pkg::FWI_MAX;
   endproperty
   a_fwi_max: assert property (p_fwi_max) else $error("wait integer above 14");

   property p_top_bit;
      rw_v && I_CMD_P1[7] |=> O_RSP_VALID && O_RSP_SW1 == 8'h6a && O_RSP_SW2 == 8'h86;
   endproperty
   a_top_bit: assert property (p_top_bit) else $error("top bit not rejected");

   property p_rsvd;
      rw_v && (I_CMD_P1[6] || I_CMD_P1[6:4] == 3'h1) |=> O_RSP_SW1 == 8'h6a;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved mode not rejected");

   property p_align;
      rw_v && !I_CMD_P1[7] && I_CMD_P1[6:5] == 2'b01 && I_CMD_P2[3:0] != 4'h0
      |=> O_RSP_SW1 == 8'h6a && O_RSP_SW2 == 8'h86;
   endproperty
   a_align: assert property (p_align) else $error("misaligned address accepted");

   property p_len;
      rw_v && !p1_err && I_CMD_P1[6:5] == 2'b01 && I_CMD_LEN[3:0] != 4'h0
      |=> O_RSP_SW1 == 8'h67 && O_RSP_SW2 == 8'h00;
   endproperty
   a_len: assert property (p_len) else $error("bad encrypted length accepted");

   property p_enc_split;
      rw_v && !p1_err && I_CMD_P1[6:5] == 2'b01
      && I_CMD_LEN[3:0] == 4'h0 && I_CMD_LEN >= 8'h20
      |=> O_PAY_OFF == 8'h10 && O_PAY_LEN == $past(I_CMD_LEN) - 8'h20
          && O_RSP_SW1 == 8'h90;
   endproperty
   a_enc_split: assert property (p_enc_split) else $error("encrypted split wrong");

   property p_plain;
      rw_v && !p1_err && I_CMD_P1[6:4] == 3'h0
      |=> O_PAY_OFF == 8'h00 && O_PAY_LEN == $past(I_CMD_LEN);
   endproperty
   a_plain: assert property (p_plain) else $error("plaintext payload wrong");

   property p_select;
      I_CMD_VALID && cmd_kind == tpc_pkg::TPC_CMD_SELECT && sel_hit
      |=> O_RSP_VALID && O_RSP_SW1 == 8'h90 && O_RSP_SW2 == 8'h00;
   endproperty
   a_select: assert property (p_select) else $error("select not completed");

   c_reqb_answer: cover property (reqb_v && afi_hit ##1 O_RSP_ANSWER);
   c_reqb_silent: cover property (reqb_v && !afi_hit);
   c_enc_ok:      cover property (rw_v && enc && !p1_err && !len_err);
   c_param_err:   cover property (rw_v && p1_err);

endmodule

// File: test/tpc_reader_model.sv
// Reader side model that issues Type B commands into the checker
`timescale 1ns/1ps
module tpc_reader_model (
   input  wire logic i_clk,
   output logic      o_valid,
   output logic [1:0] o_kind,
   output logic [7:0] o_afi,
   output logic [7:0] o_p1,
   output logic [7:0] o_p2,
   output logic [7:0] o_len
);
   initial begin
      o_valid = 1'b0;
      {o_kind, o_afi, o_p1, o_p2, o_len} = '0;
   end
   // Idle fields show the inverse, so a stale command can never pass for a fresh one
   task automatic send(input logic [1:0] k, input logic [7:0] a, q1, q2, l);
      @(posedge i_clk);
      o_valid <= 1'b1;
      {o_kind, o_afi, o_p1, o_p2, o_len} <= {k, a, q1, q2, l};
      @(posedge i_clk);
      o_valid <= 1'b0;
      {o_kind, o_afi, o_p1, o_p2, o_len} <= ~{k, a, q1, q2, l};
   endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the Type B parameter checker
`timescale 1ns/1ps
module tb_top;
   logic        clk, rst, psel, pen, pwr, fst, fsp, cv, rv, ra, pr, pe, fto, frun, e;
   logic [1:0]  ck, rm;
   logic [7:0]  afi, p1, p2, ln, s1, s2, po, pl, q1, q2, l;
   logic [11:0] pa, radr;
   logic [31:0] pw, prd, pupi, r, id;
   logic [33:0] x;
   logic [3:0]  fwi;
   logic [7:0]  afi_tab [8] = '{8'h00, 8'h30, 8'h40, 8'h05, 8'h06, 8'h35, 8'h36, 8'h53};
   logic [7:0]  ok_tab = 8'b00101011;
   int          fail_count = 0, comparisons = 0, cyc = 0, n, i, rej = 0;

   tpc_top #(.FWT_BASE_CYC(32'h4)) DUT (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pw), .O_PRDATA(prd),
      .O_PREADY(pr), .O_PSLVERR(pe), .I_CMD_VALID(cv), .I_CMD_KIND(ck), .I_CMD_AFI(afi),
      .I_CMD_P1(p1), .I_CMD_P2(p2), .I_CMD_LEN(ln), .O_RSP_VALID(rv), .O_RSP_ANSWER(ra),
      .O_RSP_SW1(s1), .O_RSP_SW2(s2), .O_RSP_MODE(rm), .O_RSP_ADDR(radr), .O_PAY_OFF(po),
      .O_PAY_LEN(pl), .O_PUPI(pupi), .O_FWI(fwi), .I_FWT_START(fst), .I_FWT_STOP(fsp),
      .O_FWT_TIMEOUT(fto), .O_FWT_RUNNING(frun));
   tpc_reader_model rdr (.i_clk(clk), .o_valid(cv), .o_kind(ck), .o_afi(afi), .o_p1(p1),
      .o_p2(p2), .o_len(ln));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop;
      end
   end
   // ------------------------------------------------------------
   // Bus master and behavioural model
   // ------------------------------------------------------------
   // No wait-state count is assumed; only the bench timeout ends a stalled access
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      {pwr, pa, pw} <= {w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pr !== 1'b1) begin
         @(posedge clk);
      end
      r = prd;
      e = pe;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Result is {mode, status word, payload offset, payload length}
   function automatic logic [33:0] model_rw(input logic [7:0] a, b, c);
      logic [2:0] m;
      logic       enc;
      m = a[6:4];
      enc = (m == 3'h2) || (m == 3'h3);
      if (a[7] || !(enc || m == 3'h0) || (enc && b[3:0] != 4'h0)) return {2'h0, 16'h6a86, 16'h0};
      if (enc && (c[3:0] != 4'h0 || c < 8'h20)) return {2'h0, 16'h6700, 16'h0};
      if (enc) return {m[0] ? 2'h2 : 2'h1, 16'h9000, 8'h10, c - 8'h20};
      return {2'h0, 16'h9000, 8'h00, c};
   endfunction
   task automatic cmd(input logic [1:0] k, input logic [7:0] a, b, c, d,
                      input logic [15:0] sw, input logic go);
      rdr.send(k, a, b, c, d);
      #1;
      chk(rv, go);
      if (go) chk({s1, s2}, sw);
      if (go && sw != 16'h9000) rej++;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h3110e05c));
      {rst, psel, pen, pwr, pa, pw, fst, fsp} = {1'b1, 47'h0, 2'b00};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, tpc_pkg::ADDR_CTRL, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, tpc_pkg::ADDR_SEL_PARAM, 32'h0);
      chk(r, 32'h0400);
      apb(1'b0, 12'h0f0, 32'h0);
      chk(e, 1'b1);
      id = $urandom;
      apb(1'b1, tpc_pkg::ADDR_ID_LO, id);
      apb(1'b1, tpc_pkg::ADDR_ID_HI, ~id);
      apb(1'b0, tpc_pkg::ADDR_PUPI, 32'h0);
      chk(r, id);
      chk(pupi, id);
      apb(1'b0, tpc_pkg::ADDR_ID_HI, 32'h0);
      chk(r, ~id);
      apb(1'b1, tpc_pkg::ADDR_CTRL, 32'h00000f35);
      apb(1'b0, tpc_pkg::ADDR_FWT, 32'h0);
      chk(r, 32'h4 << 14);
      chk(fwi, 4'he);
      for (i = 0; i < 8; i++) begin
         cmd(tpc_pkg::TPC_CMD_REQB, afi_tab[i], 8'h0, 8'h0, 8'h0, 16'h9000, ok_tab[i]);
         chk(ra, 1'b1);
      end
      cmd(tpc_pkg::TPC_CMD_SELECT, 8'h0, 8'h04, 8'h00, 8'h0, 16'h9000, 1'b1);
      cmd(tpc_pkg::TPC_CMD_SELECT, 8'h0, 8'h04, 8'h01, 8'h0, 16'h6a86, 1'b1);
      for (i = 0; i < 64; i++) begin
         q1 = {i % 13 == 0, i[2:0], 4'($urandom)};
         q2 = i[4] ? (8'($urandom) & 8'hf0) : 8'($urandom);
         l = i[5] ? 8'(32 + 16 * ($urandom % 8)) : 8'($urandom);
         x = model_rw(q1, q2, l);
         cmd(i[3] ? tpc_pkg::TPC_CMD_WRITE : tpc_pkg::TPC_CMD_READ, 8'h0, q1, q2, l,
             x[31:16], 1'b1);
         chk(po, x[15:8]);
         chk(pl, x[7:0]);
         if (x[31:16] == 16'h9000) chk(rm, x[33:32]);
         if (x[31:16] == 16'h9000) chk(radr, {q1[3:0], q2});
      end
      // Shrink the valid range so the out-of-range address check is reached
      apb(1'b1, tpc_pkg::ADDR_MEM_LAST, 32'h000000ff);
      cmd(tpc_pkg::TPC_CMD_READ, 8'h0, 8'h00, 8'hff, 8'h05, 16'h9000, 1'b1);
      chk(pl, 32'h5);
      cmd(tpc_pkg::TPC_CMD_WRITE, 8'h0, 8'h01, 8'h00, 8'h05, 16'h6a86, 1'b1);
      apb(1'b0, tpc_pkg::ADDR_STATUS, 32'h0);
      chk(r, {8'(rej), 8'h00, 16'h6a86});
      apb(1'b1, tpc_pkg::ADDR_CTRL, 32'h00000135);
      @(posedge clk);
      fst <= 1'b1;
      @(posedge clk);
      fst <= 1'b0;
      n = 0;
      while (fto !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
         if (n == 1) chk(frun, 1'b1);
      end
      chk(n, 32'h4 << 1);
      chk(frun, 1'b0);
      @(posedge clk);
      fsp <= 1'b1;
      @(posedge clk);
      fsp <= 1'b0;
      #1;
      chk(fto, 1'b0);
      report_and_stop;
   end
endmodule
